/* verif/msf_plc_model.sv */
// Logic controller model answering the auxiliary function strobes
`timescale 1ns/1ps
`default_nettype none
module msf_plc_model (
	input wire logic clock,
	input wire logic rst,
	input wire logic [3:0] answer_delay,
	input wire msf_pkg::msf_aux_s aux,
	output logic aux_function_done
);
	// ****
	// Execution handshake
	// ****
	logic [3:0] wait_cnt;
	logic any_req;
	assign any_req = aux.m_function_request | aux.speed_function_request | aux.tool_function_request |
		aux.second_tool_request;
	// Done is held until every strobe drops, so a late strobe is never missed
	always_ff @(posedge clock)
	begin
		if (rst || !any_req)
		begin
			wait_cnt <= 4'h0;
			aux_function_done <= 1'b0;
		end
		else if (wait_cnt < answer_delay)
			wait_cnt <= wait_cnt + 4'h1;
		else
			aux_function_done <= 1'b1;
	end
endmodule : msf_plc_model
`default_nettype wire

/* verif/msf_status_checker.sv */
// Concurrent checks on the status flag block ports
`timescale 1ns/1ps
`default_nettype none
module msf_status_checker #(
	parameter bit MILL_VARIANT = 1'b1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic axes_in_dead_band,
	input wire logic aux_function_done,
	input wire logic stop_key,
	input wire logic retraction_reached,
	input wire logic tool_change_fault,
	input wire logic error_memory_clear,
	input wire msf_pkg::msf_flags_s flags,
	input wire msf_pkg::msf_aux_s aux
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// Stop key counts only on the turning variant
	sequence s_stop;
		stop_key && !MILL_VARIANT;
	endsequence
	sequence s_fault;
		tool_change_fault;
	endsequence
	chk_err_set: assert property (s_fault |-> ##2 flags.tool_change_error_latch)
		else $error("error latch not set");
	chk_err_clr: assert property (error_memory_clear && !tool_change_fault |-> ##2 !flags.tool_change_error_latch)
		else $error("error latch not cleared");
	chk_wd_set: assert property (s_stop |-> ##2 flags.withdrawal_flag)
		else $error("withdrawal not set");
	chk_wd_clr: assert property (retraction_reached && !stop_key |-> ##2 !flags.withdrawal_flag)
		else $error("withdrawal not cleared");
	chk_wd_hold: assert property (!retraction_reached ##1 flags.withdrawal_flag |=> flags.withdrawal_flag)
		else $error("withdrawal dropped");
	chk_variant_only: assert property (MILL_VARIANT ? !flags.const_surface_speed_flag : !flags.synchronous_tap)
		else $error("variant flag on wrong model");
	chk_fast_run: assert property (flags.fast_traverse |-> !flags.interpolation_done_flag)
		else $error("rapid flag after end");
	chk_settle_band: assert property (!axes_in_dead_band |=> !flags.all_axes_settled)
		else $error("settled out of band");
	chk_settle_rise: assert property ($rose(flags.all_axes_settled) |-> $past(axes_in_dead_band, 3))
		else $error("settled too soon");
	chk_strobe_hold: assert property (aux.m_function_request && !aux_function_done |=> aux.m_function_request)
		else $error("m request dropped");
	chk_strobe_drop: assert property ($fell(aux.tool_function_request) |-> $past(aux_function_done))
		else $error("tool request dropped");
endmodule : msf_status_checker
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the machining status flag block
`timescale 1ns/1ps
`default_nettype none
`include "msf_consts.svh"
module tb;
	localparam bit MILL_VARIANT = 1'b0;
	localparam logic [6:0] MT [1:9] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h00, 7'h00, 7'h00, 7'h01, 7'h02};
	logic clock, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	logic is_feed, band, done, stop, reached, fault, mclr;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v, r;
	logic [1:0] bresp, rresp;
	logic [3:0] step, dly, st;
	logic [14:0] dis;
	msf_pkg::msf_flags_s flags;
	msf_pkg::msf_aux_s aux;
	int num_errors, n_compared, seed, i, j, t0;
	int q[$];
	// ****
	// Design, partner and clock
	// ****
	msf_status_outputs #(.MILL_VARIANT(MILL_VARIANT)) msf_status_outputs_i (.clock(clock), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .switch_is_feed(is_feed), .switch_step(step), .switch_position_disable(dis),
		.axes_in_dead_band(band), .aux_function_done(done), .stop_key(stop), .retraction_reached(reached),
		.tool_change_fault(fault), .error_memory_clear(mclr), .flags(flags), .aux(aux));
	msf_plc_model msf_plc_model_i (.clock(clock), .rst(rst), .answer_delay(dly), .aux(aux),
		.aux_function_done(done));
	// Free running scan clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Hang guard
	initial
	begin
		repeat (20000) @(posedge clock);
		num_errors++;
		stop_test();
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic fin(input string nm);
		$display("test %s done", nm);
	endtask : fin
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		chk("bresp", bresp, er);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		d = rdata;
		chk("rresp", rresp, er);
	endtask : axr
	// Switch model: lowest disabled step at or below chosen caps it
	function automatic logic [15:0] sw_exp(input logic f, input logic [3:0] s, input logic [14:0] m);
		logic [3:0] a;
		a = s;
		for (int n = 14; n >= 0; n--)
			if (m[n] && n <= s)
				a = (n == 0) ? 4'h0 : 4'(n - 1);
		return f ? {a, 4'h8, s, 4'h8} : {4'hf, 1'b0, s[2:0], 4'hf, 1'b0, s[2:0]};
	endfunction : sw_exp
	// Decoded flag model: programmed function or machine state
	function automatic logic [14:0] dm_exp(input logic [31:0] p, input logic [31:0] s);
		logic [3:0] g;
		for (int n = 0; n < 4; n++)
			g[n] = p[11 + n] | (s[7] && s[6:5] == n);
		return {p[0], p[1], p[2], p[10], p[3] | s[0], p[4] | s[1], p[5] | s[2], p[6] | s[2], p[9] | s[3],
			p[7] | s[4], p[8] | !s[4], g};
	endfunction : dm_exp
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	// ****
	// Main sequence
	// ****
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready, is_feed, band, stop, reached, fault, mclr} = '0;
		{awaddr, araddr, wdata, step, dis, dly} = '0;
		num_errors = 0;
		n_compared = 0;
		seed = 32'hd487d767;
		rst = 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		axr(`MSF_OFS_ANTICIP, v, 2'b00);
		chk("anticip", v, {16'h0, `MSF_ANTICIP_RESET});
		axr(`MSF_OFS_SETTLE, v, 2'b00);
		chk("settle", v, {16'h0, `MSF_SETTLE_RESET});
		axr(8'h80, v, 2'b10);
		chk("unmapped", v, 32'h0);
		axw(8'h80, 32'h1, 2'b10);
		axw(`MSF_OFS_SWITCH, 32'h0, 2'b10);
		fin("regs");
		for (i = 0; i < 31; i++)
		begin
			v = $random(seed);
			st = (i > 22) ? ((v[3:0] == 4'hf) ? 4'he : v[3:0]) : (i > 7) ? 4'(i - 8) : 4'(i);
			is_feed <= (i > 7);
			step <= st;
			dis <= (i > 22) ? v[18:4] : 15'h0;
			axr(`MSF_OFS_SWITCH, r, 2'b00);
			chk("switch", r[15:0], sw_exp(i > 7, st, (i > 22) ? v[18:4] : 15'h0));
		end
		dis <= 15'h4100;
		step <= 4'hc;
		axr(`MSF_OFS_SWITCH, r, 2'b00);
		chk("sw_dis", r[15:0], 16'h78c8);
		fin("switch");
		for (i = 1; i < 10; i++)
		begin
			axw(`MSF_OFS_MODE, (i == 9) ? 32'hc0 : 32'h1 << i, 2'b00);
			tick(2);
			chk("mode", flags[26:20], MT[i]);
		end
		axw(`MSF_OFS_MODE, 32'h1, 2'b00);
		axw(`MSF_OFS_ANTICIP, 32'h5, 2'b00);
		axw(`MSF_OFS_INTERP, 32'd40, 2'b00);
		tick(2);
		chk("run", flags[27:17], 11'h400);
		t0 = 0;
		for (j = 0; j < 100 && flags.interpolation_done_flag !== 1'b1; j++)
		begin
			@(posedge clock);
			if (flags.early_arrival_flag !== 1'b1)
				t0 = j;
		end
		chk("lead", j - t0, 7);
		chk("fast_end", flags.fast_traverse, 1'b0);
		band <= 1'b1;
		tick(5);
		chk("settle_early", flags.all_axes_settled, 1'b0);
		tick(12);
		chk("settled", flags.all_axes_settled, 1'b1);
		band <= 1'b0;
		fin("motion");
		for (i = 0; i < 12; i++)
		begin
			v = $random(seed);
			r = $random(seed);
			axw(`MSF_OFS_PROG_M, {17'h0, v[14:0]}, 2'b00);
			axw(`MSF_OFS_SPINDLE, {24'h0, r[7:0]}, 2'b00);
			tick(2);
			chk("decoded", flags[16:2], dm_exp({17'h0, v[14:0]}, {24'h0, r[7:0]}));
		end
		fin("decoded");
		dly <= 4'h8;
		axw(`MSF_OFS_MODE, 32'h200, 2'b00);
		for (i = 0; i < 10; i++)
		begin
			q.push_back({4'(i), 4'h5});
			axw(`MSF_OFS_M_FIRST + 8'(4 * i), {24'h0, 4'(i), 4'h5}, 2'b00);
		end
		axw(`MSF_OFS_STROBE, 32'hf, 2'b00);
		tick(1);
		chk("req", aux[83:80], 4'hf);
		for (i = 0; i < 10; i++)
			chk("bcd", aux[(i < 7) ? 24 + 8 * i : 8 * (9 - i) +: 8], q.pop_front());
		for (j = 0; j < 50 && aux[83:80] !== 4'h0; j++)
			@(posedge clock);
		chk("req_end", aux[83:80], 4'h0);
		dly <= 4'h0;
		axw(`MSF_OFS_MODE, 32'h0, 2'b00);
		axw(`MSF_OFS_STROBE, 32'h2, 2'b00);
		tick(2);
		chk("s_off", aux.speed_function_request, 1'b0);
		fin("strobes");
		fault <= 1'b1;
		tick(1);
		fault <= 1'b0;
		tick(5);
		axr(`MSF_OFS_ERROR, v, 2'b00);
		chk("err_reg", v[0], 1'b1);
		mclr <= 1'b1;
		tick(1);
		mclr <= 1'b0;
		fault <= 1'b1;
		tick(1);
		fault <= 1'b0;
		axw(`MSF_OFS_ERROR, 32'h1, 2'b00);
		tick(2);
		chk("err_op", flags.tool_change_error_latch, 1'b0);
		stop <= 1'b1;
		tick(1);
		stop <= 1'b0;
		tick(5);
		chk("wd", flags.withdrawal_flag, 1'b1);
		reached <= 1'b1;
		tick(1);
		reached <= 1'b0;
		tick(2);
		chk("wd_end", flags.withdrawal_flag, 1'b0);
		fin("latches");
		stop_test();
	end
endmodule : tb
bind msf_status_outputs msf_status_checker #(.MILL_VARIANT(MILL_VARIANT)) msf_status_checker_i (.clock(clock),
	.rst(rst), .axes_in_dead_band(axes_in_dead_band), .aux_function_done(aux_function_done),
	.stop_key(stop_key), .retraction_reached(retraction_reached), .tool_change_fault(tool_change_fault),
	.error_memory_clear(error_memory_clear), .flags(flags), .aux(aux));
`default_nettype wire

/* verilog/msf_consts.svh */
// Register offsets, field positions and reset values of the machining status flag block
`ifndef MSF_CONSTS_SVH
`define MSF_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define MSF_OFS_MODE 8'h00
`define MSF_OFS_INTERP 8'h04
`define MSF_OFS_ANTICIP 8'h08
`define MSF_OFS_SETTLE 8'h0c
`define MSF_OFS_SWITCH 8'h10
`define MSF_OFS_STROBE 8'h14
`define MSF_OFS_PROG_M 8'h18
`define MSF_OFS_SPINDLE 8'h1c
`define MSF_OFS_M_FIRST 8'h20
`define MSF_OFS_M_LAST 8'h38
`define MSF_OFS_S_CODE 8'h3c
`define MSF_OFS_T_CODE 8'h40
`define MSF_OFS_T2_CODE 8'h44
`define MSF_OFS_ERROR 8'h48
`define MSF_OFS_FLAGS 8'h4c

// ****************************************
// Field positions
// ****************************************
`define MSF_MODE_RAPID 0
`define MSF_MODE_TAP 1
`define MSF_MODE_SCREW_CUT_FLAG 2
`define MSF_MODE_PROBE 3
`define MSF_MODE_HOME 4
`define MSF_MODE_RIGID 5
`define MSF_MODE_RETRACE 6
`define MSF_MODE_ALL_RETRACED 7
`define MSF_MODE_CSS 8
`define MSF_MODE_SPEED_BCD 9
`define MSF_MODE_W 10
`define MSF_STB_M 0
`define MSF_STB_S 1
`define MSF_STB_T 2
`define MSF_STB_T2 3
`define MSF_SPN_CW 0
`define MSF_SPN_CCW 1
`define MSF_SPN_STOP 2
`define MSF_SPN_ORIENT 3
`define MSF_SPN_COOLANT 4
`define MSF_SPN_GEAR_LO 5
`define MSF_SPN_GEAR_VALID 7
`define MSF_PM_W 15

// ****************************************
// Reset values and encodings
// ****************************************
`define MSF_SW_HIGH_NIBBLE 4'hf
`define MSF_SW_FEED_MARK 4'h8
`define MSF_ANTICIP_RESET 16'h0000
`define MSF_SETTLE_RESET 16'h000a
`define MSF_RESP_OKAY 2'b00
`define MSF_RESP_SLVERR 2'b10

`endif

/* verilog/msf_pkg.sv */
// Types shared by the machining status flag block
package msf_pkg;

	// Flag levels handed to the logic controller every scan
	typedef struct packed {
		logic fast_traverse;
		logic tap_cycle;
		logic screw_cut_flag;
		logic touch_probing;
		logic home_search;
		logic synchronous_tap;
		logic retrace_complete_flag;
		logic const_surface_speed_flag;
		logic early_arrival_flag;
		logic interpolation_done_flag;
		logic all_axes_settled;
		logic program_stop_flag;
		logic optional_stop_flag;
		logic program_end_flag;
		logic program_rewind_flag;
		logic spindle_cw_flag;
		logic spindle_ccw_flag;
		logic spindle_halt_flag;
		logic tool_change_flag;
		logic spindle_orient_flag;
		logic coolant_on_flag;
		logic coolant_off_flag;
		logic [3:0] gear_flags;
		logic withdrawal_flag;
		logic tool_change_error_latch;
	} msf_flags_s;

	// Auxiliary function requests with their BCD payloads
	typedef struct packed {
		logic m_function_request;
		logic speed_function_request;
		logic tool_function_request;
		logic second_tool_request;
		logic [6:0][7:0] m_code_bcd;
		logic [7:0] speed_code_bcd;
		logic [7:0] tool_pocket_bcd;
		logic [7:0] return_pocket_bcd;
	} msf_aux_s;

endpackage : msf_pkg

/* verilog/msf_status_outputs.sv */
// Machining status flag outputs with an AXI4-Lite register port
`timescale 1ns/1ps
`default_nettype none
`include "msf_consts.svh"

// Behaviour
// RULE_01: Rapid flag high while a rapid move runs.
// RULE_02: Tap flag in tapping cycle, screw-cut flag in threading.
// RULE_03: Probe flag while probing, home flag in reference search.
// RULE_04: Milling only: synchronous-tap flag during rigid tapping.
// RULE_05: Retrace-complete flag when retracing and all blocks retraced.
// RULE_06: Turning only: surface-speed flag while selected.
// RULE_07: Handwheel and jog: upper nibble ones plus consecutive index.
// RULE_08: Feed override: bit three set, step index in upper nibble.
// RULE_09: Chosen and applied positions apart; disabled ones fall back.
// RULE_10: M strobe requests the seven M-code BCD values.
// RULE_11: Speed strobe requests speed BCD value on BCD spindle.
// RULE_12: Tool strobe carries selected tool pocket in BCD.
// RULE_13: Second tool strobe carries pocket for outgoing tool.
// RULE_14: Early-arrival flag leads arrival by anticipation time.
// RULE_15: Interpolation-done low while running, high once ended.
// RULE_16: Settled only after dead band held for settle time.
// RULE_17: Decoded stop, optional stop, end and rewind flags.
// RULE_18: Spindle direction, halt, tool, orient flags from state or program.
// RULE_19: Coolant on or off flag from state or program.
// RULE_20: Gear flags from selected or programmed gear.
// RULE_21: Turning only: withdrawal from stop until retraction reached.
// RULE_22: Tool-change error latches until memory or operator clear.
// RULE_23: All flags update together once per scan.
module msf_status_outputs #(
	parameter bit MILL_VARIANT = 1'b1,
	parameter int ADDR_W = 8
) (
	input wire logic clock,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Front-panel switch and machine-side inputs
	input wire logic switch_is_feed,
	input wire logic [3:0] switch_step,
	input wire logic [14:0] switch_position_disable,
	input wire logic axes_in_dead_band,
	input wire logic aux_function_done,
	input wire logic stop_key,
	input wire logic retraction_reached,
	input wire logic tool_change_fault,
	input wire logic error_memory_clear,
	// Outputs to the logic controller
	output msf_pkg::msf_flags_s flags,
	output msf_pkg::msf_aux_s aux
);

	// ****************************************
	// Registers and state
	// ****************************************
	logic [`MSF_MODE_W-1:0] mode;
	logic [31:0] interp_left;
	logic [15:0] anticipation_time;
	logic [15:0] settle_time;
	logic [15:0] settle_count;
	logic [7:0] switch_chosen_position;
	logic [7:0] applied_switch;
	logic [`MSF_PM_W-1:0] prog_m;
	logic [7:0] spindle_state;
	logic withdrawing;
	logic err_latch;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_go;
	logic [31:0] rd_word;
	logic rd_hit;
	logic [7:0] next_applied;
	logic [3:0] m_index;
	msf_pkg::msf_flags_s next_flags;

	// Operator clear comes from a write of one to bit 0 of the error register
	logic op_clear;
	assign op_clear = wr_go && wr_addr == ADDR_W'(`MSF_OFS_ERROR) && wr_strb[0] && wr_data[0];

	// Byte-lane merge so partial writes keep untouched lanes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
				r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction : merge

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	// AW and W taken together, so arrival order does not matter
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `MSF_RESP_OKAY;
			wr_go <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= '0;
		end
		else
		begin
			wr_go <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid && !wr_go)
			begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awready)
			begin
				wr_go <= 1'b1;
				wr_addr <= s_axi_awaddr;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr[1:0] == 2'b00 && wr_addr <= ADDR_W'(`MSF_OFS_ERROR)
					&& wr_addr != ADDR_W'(`MSF_OFS_SWITCH)) ? `MSF_RESP_OKAY : `MSF_RESP_SLVERR;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// Software-written configuration and payloads
	// ****************************************
	// Mode bits, programmed functions, spindle state and timing settings
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode <= '0;
			prog_m <= '0;
			spindle_state <= '0;
			anticipation_time <= `MSF_ANTICIP_RESET;
			settle_time <= `MSF_SETTLE_RESET;
		end
		else if (wr_go)
		begin
			case (wr_addr)
				ADDR_W'(`MSF_OFS_MODE): mode <= `MSF_MODE_W'(merge(32'(mode), wr_data, wr_strb));
				ADDR_W'(`MSF_OFS_PROG_M): prog_m <= `MSF_PM_W'(merge(32'(prog_m), wr_data, wr_strb));
				ADDR_W'(`MSF_OFS_SPINDLE): spindle_state <= 8'(merge(32'(spindle_state), wr_data, wr_strb));
				ADDR_W'(`MSF_OFS_ANTICIP): anticipation_time <= 16'(merge(32'(anticipation_time), wr_data, wr_strb));
				ADDR_W'(`MSF_OFS_SETTLE): settle_time <= 16'(merge(32'(settle_time), wr_data, wr_strb));
				default: ;
			endcase
		end
	end

	// BCD payloads; each register keeps byte lane 0 of the written word
	assign m_index = 4'((wr_addr - ADDR_W'(`MSF_OFS_M_FIRST)) >> 2);
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			aux.m_code_bcd <= '0;
			aux.speed_code_bcd <= '0;
			aux.tool_pocket_bcd <= '0;
			aux.return_pocket_bcd <= '0;
		end
		else if (wr_go && wr_strb[0])
		begin
			if (wr_addr >= ADDR_W'(`MSF_OFS_M_FIRST) && wr_addr <= ADDR_W'(`MSF_OFS_M_LAST) && wr_addr[1:0] == 2'b00)
				aux.m_code_bcd[m_index[2:0]] <= wr_data[7:0]; // [RULE_10]
			if (wr_addr == ADDR_W'(`MSF_OFS_S_CODE))
				aux.speed_code_bcd <= wr_data[7:0]; // [RULE_11]
			if (wr_addr == ADDR_W'(`MSF_OFS_T_CODE))
				aux.tool_pocket_bcd <= wr_data[7:0]; // [RULE_12]
			if (wr_addr == ADDR_W'(`MSF_OFS_T2_CODE))
				aux.return_pocket_bcd <= wr_data[7:0]; // [RULE_13]
		end
	end

	// ****************************************
	// Auxiliary function strobes
	// ****************************************
	// Strobes hold until the controller reports done; a new request in that cycle wins
	logic strobe_wr;
	assign strobe_wr = wr_go && wr_addr == ADDR_W'(`MSF_OFS_STROBE) && wr_strb[0];
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			aux.m_function_request <= 1'b0;
			aux.speed_function_request <= 1'b0;
			aux.tool_function_request <= 1'b0;
			aux.second_tool_request <= 1'b0;
		end
		else
		begin
			aux.m_function_request <= (strobe_wr && wr_data[`MSF_STB_M])
				|| (aux.m_function_request && !aux_function_done); // [RULE_10]
			// Speed strobe is meaningless unless the spindle takes a BCD speed
			aux.speed_function_request <= (strobe_wr && wr_data[`MSF_STB_S] && mode[`MSF_MODE_SPEED_BCD])
				|| (aux.speed_function_request && !aux_function_done); // [RULE_11]
			aux.tool_function_request <= (strobe_wr && wr_data[`MSF_STB_T])
				|| (aux.tool_function_request && !aux_function_done); // [RULE_12]
			aux.second_tool_request <= (strobe_wr && wr_data[`MSF_STB_T2])
				|| (aux.second_tool_request && !aux_function_done); // [RULE_13]
		end
	end

	// ****************************************
	// Interpolation, anticipation and settling
	// ****************************************
	// Writing a cycle count starts an interpolation that runs down to zero
	always_ff @(posedge clock)
	begin
		if (rst)
			interp_left <= '0;
		else if (wr_go && wr_addr == ADDR_W'(`MSF_OFS_INTERP))
			interp_left <= merge(interp_left, wr_data, wr_strb);
		else if (interp_left != '0)
			interp_left <= interp_left - 32'h1; // [RULE_15]
	end

	// Dead-band time restarts when an axis leaves or motion resumes
	always_ff @(posedge clock)
	begin
		if (rst)
			settle_count <= '0;
		else if (!axes_in_dead_band || interp_left != '0)
			settle_count <= '0;
		else if (settle_count != settle_time)
			settle_count <= settle_count + 16'h1; // [RULE_16]
	end

	// ****************************************
	// Withdrawal and tool-change error
	// ****************************************
	// Withdrawal only exists on the turning variant
	always_ff @(posedge clock)
	begin
		if (rst)
			withdrawing <= 1'b0;
		else if (!MILL_VARIANT && stop_key)
			withdrawing <= 1'b1; // [RULE_21]
		else if (retraction_reached)
			withdrawing <= 1'b0; // [RULE_21]
	end

	// A fault arriving while either clear is active still latches
	always_ff @(posedge clock)
	begin
		if (rst)
			err_latch <= 1'b0;
		else if (tool_change_fault)
			err_latch <= 1'b1; // [RULE_22]
		else if (error_memory_clear || op_clear)
			err_latch <= 1'b0; // [RULE_22]
	end

	// ****************************************
	// Switch encoding
	// ****************************************
	// A disabled feed step caps the applied value below it
	always_comb
	begin
		logic found;
		found = 1'b0;
		next_applied = {switch_step, `MSF_SW_FEED_MARK}; // [RULE_08]
		if (!switch_is_feed)
			next_applied = {`MSF_SW_HIGH_NIBBLE, 1'b0, switch_step[2:0]}; // [RULE_07]
		else
		begin
			for (int i = 0; i < 15; i++)
			begin
				if (!found && switch_position_disable[i] && 4'(i) <= switch_step)
				begin
					found = 1'b1;
					next_applied = {(i == 0) ? 4'h0 : 4'(i - 1), `MSF_SW_FEED_MARK}; // [RULE_09]
				end
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			switch_chosen_position <= '0;
			applied_switch <= '0;
		end
		else
		begin
			switch_chosen_position <= switch_is_feed ? {switch_step, `MSF_SW_FEED_MARK}
				: {`MSF_SW_HIGH_NIBBLE, 1'b0, switch_step[2:0]}; // [RULE_09]
			applied_switch <= next_applied;
		end
	end

	// ****************************************
	// Flag set, registered once per scan
	// ****************************************
	always_comb
	begin
		next_flags = '0;
		next_flags.fast_traverse = mode[`MSF_MODE_RAPID] && interp_left != '0; // [RULE_01]
		next_flags.tap_cycle = mode[`MSF_MODE_TAP]; // [RULE_02]
		next_flags.screw_cut_flag = mode[`MSF_MODE_SCREW_CUT_FLAG]; // [RULE_02]
		next_flags.touch_probing = mode[`MSF_MODE_PROBE]; // [RULE_03]
		next_flags.home_search = mode[`MSF_MODE_HOME]; // [RULE_03]
		next_flags.synchronous_tap = MILL_VARIANT && mode[`MSF_MODE_RIGID]; // [RULE_04]
		next_flags.retrace_complete_flag = mode[`MSF_MODE_RETRACE] && mode[`MSF_MODE_ALL_RETRACED]; // [RULE_05]
		next_flags.const_surface_speed_flag = !MILL_VARIANT && mode[`MSF_MODE_CSS]; // [RULE_06]
		// Zero anticipation collapses to arrival
		next_flags.early_arrival_flag = interp_left <= 32'(anticipation_time); // [RULE_14]
		next_flags.interpolation_done_flag = interp_left == '0; // [RULE_15]
		next_flags.all_axes_settled = axes_in_dead_band && interp_left == '0
			&& settle_count == settle_time; // [RULE_16]
		next_flags.program_stop_flag = prog_m[0]; // [RULE_17]
		next_flags.optional_stop_flag = prog_m[1]; // [RULE_17]
		next_flags.program_end_flag = prog_m[2]; // [RULE_17]
		next_flags.program_rewind_flag = prog_m[10]; // [RULE_17]
		next_flags.spindle_cw_flag = spindle_state[`MSF_SPN_CW] || prog_m[3]; // [RULE_18]
		next_flags.spindle_ccw_flag = spindle_state[`MSF_SPN_CCW] || prog_m[4]; // [RULE_18]
		next_flags.spindle_halt_flag = spindle_state[`MSF_SPN_STOP] || prog_m[5]; // [RULE_18]
		next_flags.tool_change_flag = spindle_state[`MSF_SPN_STOP] || prog_m[6]; // [RULE_18]
		next_flags.spindle_orient_flag = spindle_state[`MSF_SPN_ORIENT] || prog_m[9]; // [RULE_18]
		next_flags.coolant_on_flag = spindle_state[`MSF_SPN_COOLANT] || prog_m[7]; // [RULE_19]
		next_flags.coolant_off_flag = !spindle_state[`MSF_SPN_COOLANT] || prog_m[8]; // [RULE_19]
		for (int g = 0; g < 4; g++)
			next_flags.gear_flags[g] = (spindle_state[`MSF_SPN_GEAR_VALID]
				&& spindle_state[`MSF_SPN_GEAR_LO +: 2] == 2'(g)) || prog_m[11 + g]; // [RULE_20]
		next_flags.withdrawal_flag = withdrawing; // [RULE_21]
		next_flags.tool_change_error_latch = err_latch; // [RULE_22]
	end

	// One stage so the controller samples a coherent set
	always_ff @(posedge clock)
	begin
		if (rst)
			flags <= '0;
		else
			flags <= next_flags; // [RULE_23]
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	always_comb
	begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			ADDR_W'(`MSF_OFS_MODE): rd_word = 32'(mode);
			ADDR_W'(`MSF_OFS_INTERP): rd_word = interp_left;
			ADDR_W'(`MSF_OFS_ANTICIP): rd_word = 32'(anticipation_time);
			ADDR_W'(`MSF_OFS_SETTLE): rd_word = 32'(settle_time);
			ADDR_W'(`MSF_OFS_SWITCH): rd_word = {16'h0000, applied_switch, switch_chosen_position};
			ADDR_W'(`MSF_OFS_STROBE): rd_word = {28'h0000000, aux.second_tool_request, aux.tool_function_request,
				aux.speed_function_request, aux.m_function_request};
			ADDR_W'(`MSF_OFS_PROG_M): rd_word = 32'(prog_m);
			ADDR_W'(`MSF_OFS_SPINDLE): rd_word = 32'(spindle_state);
			ADDR_W'(`MSF_OFS_S_CODE): rd_word = 32'(aux.speed_code_bcd);
			ADDR_W'(`MSF_OFS_T_CODE): rd_word = 32'(aux.tool_pocket_bcd);
			ADDR_W'(`MSF_OFS_T2_CODE): rd_word = 32'(aux.return_pocket_bcd);
			ADDR_W'(`MSF_OFS_ERROR): rd_word = 32'(err_latch);
			ADDR_W'(`MSF_OFS_FLAGS): rd_word = 32'(flags);
			default:
			begin
				rd_word = 32'h0;
				rd_hit = 1'b0;
				if (s_axi_araddr >= ADDR_W'(`MSF_OFS_M_FIRST) && s_axi_araddr <= ADDR_W'(`MSF_OFS_M_LAST)
					&& s_axi_araddr[1:0] == 2'b00)
				begin
					rd_word = 32'(aux.m_code_bcd[3'((s_axi_araddr - ADDR_W'(`MSF_OFS_M_FIRST)) >> 2)]);
					rd_hit = 1'b1;
				end
			end
		endcase
	end

	// Address taken a cycle after arvalid, data on the next edge
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `MSF_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_hit ? `MSF_RESP_OKAY : `MSF_RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

endmodule : msf_status_outputs
`default_nettype wire
